// ===== piv_pkg.sv
// package: constants, register map and vector table of the interrupt controller
package piv_pkg;

   localparam int NUM_LEVELS = 11;
   localparam int IDX_W = 4;
   localparam int VEC_W = 16;

   // level index, 0 is highest maskable-side priority
   localparam logic [IDX_W-1:0] LVL_POWERDOWN = 4'h0;
   localparam logic [IDX_W-1:0] LVL_EDGE_OR_LEVEL = 4'h1;
   localparam logic [IDX_W-1:0] LVL_LEVEL_A = 4'h2;
   localparam logic [IDX_W-1:0] LVL_LEVEL_B = 4'h3;
   localparam logic [IDX_W-1:0] LVL_SP0_XMIT = 4'h4;
   localparam logic [IDX_W-1:0] LVL_SP0_RECV = 4'h5;
   localparam logic [IDX_W-1:0] LVL_EDGE_IRQ = 4'h6;
   localparam logic [IDX_W-1:0] LVL_BYTE_DMA_PORT = 4'h7;
   localparam logic [IDX_W-1:0] LVL_SP1_XMIT = 4'h8;
   localparam logic [IDX_W-1:0] LVL_SP1_RECV = 4'h9;
   localparam logic [IDX_W-1:0] LVL_TIMER = 4'hA;
   localparam logic [IDX_W-1:0] LVL_RESET = 4'hF;

   // vector addresses
   localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
   localparam logic [VEC_W-1:0] VEC_POWERDOWN = 16'h002C;
   localparam logic [VEC_W-1:0] VEC_EDGE_OR_LEVEL = 16'h0004;
   localparam logic [VEC_W-1:0] VEC_LEVEL_A = 16'h0008;
   localparam logic [VEC_W-1:0] VEC_LEVEL_B = 16'h000C;
   localparam logic [VEC_W-1:0] VEC_SP0_XMIT = 16'h0010;
   localparam logic [VEC_W-1:0] VEC_SP0_RECV = 16'h0014;
   localparam logic [VEC_W-1:0] VEC_EDGE_IRQ = 16'h0018;
   localparam logic [VEC_W-1:0] VEC_BYTE_DMA_PORT = 16'h001C;
   localparam logic [VEC_W-1:0] VEC_SP1_XMIT = 16'h0020;
   localparam logic [VEC_W-1:0] VEC_SP1_RECV = 16'h0024;
   localparam logic [VEC_W-1:0] VEC_TIMER = 16'h0028;

   // shared flag pin positions within the four-pin group
   localparam int PIN_EDGE_IRQ = 0;
   localparam int PIN_LEVEL_B = 1;
   localparam int PIN_LEVEL_A = 2;
   localparam int PIN_EDGE_OR_LEVEL = 3;

   // register byte offsets
   localparam logic [7:0] ADDR_MASK = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_FLAG = 8'h08;
   localparam logic [7:0] ADDR_FORCE = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // control register fields
   localparam int CTRL_EDGE_OR_LEVEL_EDGE = 0;
   localparam int CTRL_RECV_FRAME_EDGE = 1;
   localparam int CTRL_XMIT_FRAME_EDGE = 2;
   localparam int CTRL_SP1_IRQ_MODE = 3;
   localparam int CTRL_POWERUP_CONTEXT = 4;
   localparam int CTRL_SP1_FLAG_OUT = 5;
   localparam int CTRL_W = 6;

   // flag register fields
   localparam int FLAG_OE_LSB = 0;
   localparam int FLAG_OUT_LSB = 4;
   localparam int FLAG_W = 8;

   // status register fields
   localparam int STAT_PEND_LSB = 0;
   localparam int STAT_VALID = 11;
   localparam int STAT_IDX_LSB = 12;
   localparam int STAT_PIN_LSB = 16;
   localparam int STAT_SP1_FLAG_IN = 20;
   localparam int STAT_RESET_PEND = 21;

   // reset values
   localparam logic [NUM_LEVELS-1:0] MASK_RST = 11'h000;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
   localparam logic [FLAG_W-1:0] FLAG_RST = 8'h00;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } piv_bus_e;

   function automatic logic [VEC_W-1:0] piv_vector_of(input logic [IDX_W-1:0] idx);
      logic [VEC_W-1:0] v;
      v = VEC_RESET;
      case (idx)
         LVL_POWERDOWN: v = VEC_POWERDOWN;
         LVL_EDGE_OR_LEVEL: v = VEC_EDGE_OR_LEVEL;
         LVL_LEVEL_A: v = VEC_LEVEL_A;
         LVL_LEVEL_B: v = VEC_LEVEL_B;
         LVL_SP0_XMIT: v = VEC_SP0_XMIT;
         LVL_SP0_RECV: v = VEC_SP0_RECV;
         LVL_EDGE_IRQ: v = VEC_EDGE_IRQ;
         LVL_BYTE_DMA_PORT: v = VEC_BYTE_DMA_PORT;
         LVL_SP1_XMIT: v = VEC_SP1_XMIT;
         LVL_SP1_RECV: v = VEC_SP1_RECV;
         LVL_TIMER: v = VEC_TIMER;
         default: v = VEC_RESET;
      endcase
      return v;
   endfunction

endpackage

// ===== piv_irq_detect.sv
// request detector for one active-low interrupt pin, level or falling edge
`timescale 1ns/1ps
module piv_irq_detect (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic pinLevel,
   input wire logic edgeMode,
   input wire logic clearEdge,
   output logic request
);
   logic prevLevel_reg;
   logic prevLevel_next;
   logic edgeLatch_reg;
   logic edgeLatch_next;
   logic fallSeen;

   always_comb begin
      fallSeen = prevLevel_reg & ~pinLevel;
      prevLevel_next = pinLevel;
      // a new edge beats a clear in the same cycle
      edgeLatch_next = (edgeLatch_reg & ~clearEdge) | fallSeen;
      request = edgeMode ? edgeLatch_reg : ~pinLevel;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prevLevel_reg <= 1'b1;
         edgeLatch_reg <= 1'b0;
      end else begin
         prevLevel_reg <= prevLevel_next;
         edgeLatch_reg <= edgeLatch_next;
      end
   end
endmodule

// ===== piv_priority_pick.sv
// fixed priority picker, lowest index wins
`timescale 1ns/1ps
module piv_priority_pick #(
   parameter int N = 11
) (
   input wire logic [N-1:0] pending,
   output logic [3:0] winner,
   output logic found
);
   always_comb begin
      winner = 4'h0;
      found = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pending[i]) begin
            winner = 4'(i);
            found = 1'b1;
         end
      end
   end
endmodule

// ===== piv_controller.sv
// prioritized vectoring interrupt controller with Avalon-MM register slave
// Function
// R1 - eleven sources plus reset, each vectored
// R2 - four dedicated external request pins, flag-shared
// R3 - serial port one pins become two requests
// R4 - internal timer, dma, serial, software, power-down
// R5 - all maskable except reset and power-down
// R6 - three pins selectable level or edge
// R7 - two pins level only, one edge only
// R8 - reset highest, vector 0000, also power-up
// R9 - vectors for power-down through edge pin
// R10 - vectors for dma, serial one, timer
// R11 - fixed descending priority order
// R12 - pins come up inputs, high inactive
// R13 - flag-driven pin level also requests interrupt
// R14 - highest served first, others stay pending
`timescale 1ns/1ps
module piv_controller (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [3:0] flagPinIn,
   output logic [3:0] flagPinOut,
   output logic [3:0] flagPinOe,
   input wire logic s1RecvFrameIrqPin,
   input wire logic s1XmitFrameIrqPin,
   input wire logic serial1FlagInput,
   output logic serial1FlagOutput,
   input wire logic timerEvent,
   input wire logic bdmaDoneEvent,
   input wire logic sp0XmitEvent,
   input wire logic sp0RecvEvent,
   input wire logic sp1XmitEvent,
   input wire logic sp1RecvEvent,
   input wire logic powerDownEvent,
   input wire logic powerUpWake,
   input wire logic vectorTaken,
   output logic vectorValid,
   output logic [15:0] vectorAddr
);
   localparam int N = piv_pkg::NUM_LEVELS;

   // register file state
   logic [N-1:0] mask_reg;
   logic [N-1:0] mask_next;
   logic [piv_pkg::CTRL_W-1:0] ctrl_reg;
   logic [piv_pkg::CTRL_W-1:0] ctrl_next;
   logic [piv_pkg::FLAG_W-1:0] flag_reg;
   logic [piv_pkg::FLAG_W-1:0] flag_next;

   // bus slave state
   piv_pkg::piv_bus_e bus_reg;
   piv_pkg::piv_bus_e bus_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // latched internal and software requests
   logic [N-1:0] evtLatch_reg;
   logic [N-1:0] evtLatch_next;
   logic resetPend_reg;
   logic resetPend_next;

   // vector presentation
   logic vecValid_reg;
   logic vecValid_next;
   logic [15:0] vecAddr_reg;
   logic [15:0] vecAddr_next;
   logic [3:0] vecIdx_reg;
   logic [3:0] vecIdx_next;

   // combinational helpers
   logic [3:0] pinLevel;
   logic reqEdgeOrLevel;
   logic reqLevelA;
   logic reqLevelB;
   logic reqEdgeIrq;
   logic reqRecvFrame;
   logic reqXmitFrame;
   logic served;
   logic [N-1:0] serveMask;
   logic [N-1:0] evtSet;
   logic [N-1:0] swSet;
   logic [N-1:0] swClr;
   logic [N-1:0] pinReq;
   logic [N-1:0] pending;
   logic [N-1:0] enabled;
   logic [3:0] winIdx;
   logic winFound;
   logic busAccept;
   logic wrHit;
   logic sp1IrqMode;

   function automatic logic [N-1:0] piv_onehot(input logic [3:0] idx);
      logic [N-1:0] oh;
      oh = '0;
      for (int i = 0; i < N; i++) begin
         if (4'(i) == idx) begin
            oh[i] = 1'b1;
         end
      end
      return oh;
   endfunction

   // pin level as seen on the wire, flag output drives it when enabled
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pinLevel[i] = flagPinOe[i] ? flagPinOut[i] : flagPinIn[i]; // R13
      end
   end

   assign sp1IrqMode = ctrl_reg[piv_pkg::CTRL_SP1_IRQ_MODE];
   assign served = vecValid_reg & vectorTaken;
   assign serveMask = served ? piv_onehot(vecIdx_reg) : '0;

   // dedicated pin detectors
   piv_irq_detect u_edgeOrLevel (
      .clock(clock),
      .reset_n(reset_n),
      .pinLevel(pinLevel[piv_pkg::PIN_EDGE_OR_LEVEL]),
      .edgeMode(ctrl_reg[piv_pkg::CTRL_EDGE_OR_LEVEL_EDGE]), // R6
      .clearEdge(serveMask[piv_pkg::LVL_EDGE_OR_LEVEL]),
      .request(reqEdgeOrLevel)
   );

   piv_irq_detect u_levelA (
      .clock(clock),
      .reset_n(reset_n),
      .pinLevel(pinLevel[piv_pkg::PIN_LEVEL_A]),
      .edgeMode(1'b0), // R7
      .clearEdge(serveMask[piv_pkg::LVL_LEVEL_A]),
      .request(reqLevelA)
   );

   piv_irq_detect u_levelB (
      .clock(clock),
      .reset_n(reset_n),
      .pinLevel(pinLevel[piv_pkg::PIN_LEVEL_B]),
      .edgeMode(1'b0), // R7
      .clearEdge(serveMask[piv_pkg::LVL_LEVEL_B]),
      .request(reqLevelB)
   );

   piv_irq_detect u_edgeIrq (
      .clock(clock),
      .reset_n(reset_n),
      .pinLevel(pinLevel[piv_pkg::PIN_EDGE_IRQ]),
      .edgeMode(1'b1), // R7
      .clearEdge(serveMask[piv_pkg::LVL_EDGE_IRQ]),
      .request(reqEdgeIrq)
   );

   // serial port one frame-sync pins as requests
   piv_irq_detect u_recvFrame (
      .clock(clock),
      .reset_n(reset_n),
      .pinLevel(s1RecvFrameIrqPin),
      .edgeMode(ctrl_reg[piv_pkg::CTRL_RECV_FRAME_EDGE]), // R6
      .clearEdge(serveMask[piv_pkg::LVL_SP1_RECV]),
      .request(reqRecvFrame)
   );

   piv_irq_detect u_xmitFrame (
      .clock(clock),
      .reset_n(reset_n),
      .pinLevel(s1XmitFrameIrqPin),
      .edgeMode(ctrl_reg[piv_pkg::CTRL_XMIT_FRAME_EDGE]), // R6
      .clearEdge(serveMask[piv_pkg::LVL_SP1_XMIT]),
      .request(reqXmitFrame)
   );

   // gather all eleven levels
   always_comb begin
      pinReq = '0;
      pinReq[piv_pkg::LVL_EDGE_OR_LEVEL] = reqEdgeOrLevel; // R2
      pinReq[piv_pkg::LVL_LEVEL_A] = reqLevelA; // R2
      pinReq[piv_pkg::LVL_LEVEL_B] = reqLevelB; // R2
      pinReq[piv_pkg::LVL_EDGE_IRQ] = reqEdgeIrq; // R2
      pinReq[piv_pkg::LVL_SP1_XMIT] = sp1IrqMode & reqXmitFrame; // R3
      pinReq[piv_pkg::LVL_SP1_RECV] = sp1IrqMode & reqRecvFrame; // R3
      evtSet = '0;
      evtSet[piv_pkg::LVL_POWERDOWN] = powerDownEvent; // R4
      evtSet[piv_pkg::LVL_SP0_XMIT] = sp0XmitEvent; // R4
      evtSet[piv_pkg::LVL_SP0_RECV] = sp0RecvEvent; // R4
      evtSet[piv_pkg::LVL_BYTE_DMA_PORT] = bdmaDoneEvent; // R4
      evtSet[piv_pkg::LVL_SP1_XMIT] = ~sp1IrqMode & sp1XmitEvent; // R4
      evtSet[piv_pkg::LVL_SP1_RECV] = ~sp1IrqMode & sp1RecvEvent; // R4
      evtSet[piv_pkg::LVL_TIMER] = timerEvent; // R4
      // pending before mask, as status shows it
      pending = evtLatch_reg | pinReq; // R1
      enabled = pending & mask_reg; // R5
      // power-down bypasses its mask bit
      enabled[piv_pkg::LVL_POWERDOWN] = pending[piv_pkg::LVL_POWERDOWN]; // R5
   end

   piv_priority_pick #(
      .N(N)
   ) u_pick (
      .pending(enabled),
      .winner(winIdx), // R11
      .found(winFound)
   );

   // event and software latches, a new event beats its clear
   always_comb begin
      evtLatch_next = (evtLatch_reg & ~serveMask & ~swClr) | evtSet | swSet; // R14
      resetPend_next = resetPend_reg;
      if (served && vecIdx_reg == piv_pkg::LVL_RESET) begin
         resetPend_next = 1'b0;
      end
      if (powerUpWake && ctrl_reg[piv_pkg::CTRL_POWERUP_CONTEXT]) begin
         resetPend_next = 1'b1; // R8
      end
   end

   // vector presentation to the sequencer
   always_comb begin
      vecValid_next = 1'b0;
      vecIdx_next = vecIdx_reg;
      vecAddr_next = vecAddr_reg;
      // reset vector outranks every level
      if (served) begin
         vecValid_next = 1'b0;
      end else if (resetPend_reg) begin
         vecValid_next = 1'b1; // R8
         vecIdx_next = piv_pkg::LVL_RESET;
         vecAddr_next = piv_pkg::VEC_RESET; // R8
      end else if (winFound) begin
         vecValid_next = 1'b1; // R14
         vecIdx_next = winIdx;
         vecAddr_next = piv_pkg::piv_vector_of(winIdx); // R9 R10
      end
   end

   // Avalon slave: one wait cycle, then answer
   always_comb begin
      bus_next = bus_reg;
      rdata_next = rdata_reg;
      busAccept = 1'b0;
      case (bus_reg)
         piv_pkg::BUS_IDLE: begin
            if (avs_read || avs_write) begin
               bus_next = piv_pkg::BUS_ANSWER;
               rdata_next = 32'h0000_0000;
               if (avs_read) begin
                  if (avs_address == piv_pkg::ADDR_MASK) begin
                     rdata_next[N-1:0] = mask_reg;
                  end else if (avs_address == piv_pkg::ADDR_CTRL) begin
                     rdata_next[piv_pkg::CTRL_W-1:0] = ctrl_reg;
                  end else if (avs_address == piv_pkg::ADDR_FLAG) begin
                     rdata_next[piv_pkg::FLAG_W-1:0] = flag_reg;
                  end else if (avs_address == piv_pkg::ADDR_FORCE) begin
                     rdata_next[N-1:0] = evtLatch_reg;
                  end else if (avs_address == piv_pkg::ADDR_STATUS) begin
                     rdata_next[piv_pkg::STAT_PEND_LSB +: N] = pending;
                     rdata_next[piv_pkg::STAT_VALID] = vecValid_reg;
                     rdata_next[piv_pkg::STAT_IDX_LSB +: 4] = vecIdx_reg;
                     rdata_next[piv_pkg::STAT_PIN_LSB +: 4] = pinLevel;
                     rdata_next[piv_pkg::STAT_SP1_FLAG_IN] = serial1FlagInput;
                     rdata_next[piv_pkg::STAT_RESET_PEND] = resetPend_reg;
                  end else begin
                     rdata_next = 32'h0000_0000;
                  end
               end
            end
         end
         piv_pkg::BUS_ANSWER: begin
            busAccept = 1'b1;
            bus_next = piv_pkg::BUS_IDLE;
         end
         default: begin
            bus_next = piv_pkg::BUS_IDLE;
         end
      endcase
   end

   // write lands on the answer edge
   assign wrHit = busAccept & avs_write;

   // register writes
   always_comb begin
      mask_next = mask_reg;
      ctrl_next = ctrl_reg;
      flag_next = flag_reg;
      // force sets, status write clears
      swSet = '0;
      swClr = '0;
      if (wrHit) begin
         if (avs_address == piv_pkg::ADDR_MASK) begin
            mask_next = avs_writedata[N-1:0];
         end else if (avs_address == piv_pkg::ADDR_CTRL) begin
            ctrl_next = avs_writedata[piv_pkg::CTRL_W-1:0];
         end else if (avs_address == piv_pkg::ADDR_FLAG) begin
            flag_next = avs_writedata[piv_pkg::FLAG_W-1:0];
         end else if (avs_address == piv_pkg::ADDR_FORCE) begin
            swSet = avs_writedata[N-1:0]; // R4
         end else if (avs_address == piv_pkg::ADDR_STATUS) begin
            swClr = avs_writedata[N-1:0];
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mask_reg <= piv_pkg::MASK_RST;
         ctrl_reg <= piv_pkg::CTRL_RST;
         flag_reg <= piv_pkg::FLAG_RST; // R12
         bus_reg <= piv_pkg::BUS_IDLE;
         rdata_reg <= 32'h0000_0000;
         evtLatch_reg <= '0;
         resetPend_reg <= 1'b1; // R8
         vecValid_reg <= 1'b0;
         vecIdx_reg <= piv_pkg::LVL_RESET;
         vecAddr_reg <= piv_pkg::VEC_RESET;
      end else begin
         mask_reg <= mask_next;
         ctrl_reg <= ctrl_next;
         flag_reg <= flag_next;
         bus_reg <= bus_next;
         rdata_reg <= rdata_next;
         evtLatch_reg <= evtLatch_next;
         resetPend_reg <= resetPend_next;
         vecValid_reg <= vecValid_next;
         vecIdx_reg <= vecIdx_next;
         vecAddr_reg <= vecAddr_next;
      end
   end

   // outputs straight from flops
   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = (bus_reg == piv_pkg::BUS_IDLE);
   assign flagPinOe = flag_reg[piv_pkg::FLAG_OE_LSB +: 4]; // R12
   assign flagPinOut = flag_reg[piv_pkg::FLAG_OUT_LSB +: 4];
   assign serial1FlagOutput = ctrl_reg[piv_pkg::CTRL_SP1_FLAG_OUT]; // R3
   assign vectorValid = vecValid_reg;
   assign vectorAddr = vecAddr_reg;

endmodule

// ===== piv_monitor.sv
// assertion checker bound to the interrupt controller ports
`timescale 1ns/1ps
module piv_checker (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [3:0] flagPinIn,
   input wire logic [3:0] flagPinOut,
   input wire logic [3:0] flagPinOe,
   input wire logic s1RecvFrameIrqPin,
   input wire logic s1XmitFrameIrqPin,
   input wire logic serial1FlagInput,
   input wire logic serial1FlagOutput,
   input wire logic timerEvent,
   input wire logic bdmaDoneEvent,
   input wire logic sp0XmitEvent,
   input wire logic sp0RecvEvent,
   input wire logic sp1XmitEvent,
   input wire logic sp1RecvEvent,
   input wire logic powerDownEvent,
   input wire logic powerUpWake,
   input wire logic vectorTaken,
   input wire logic vectorValid,
   input wire logic [15:0] vectorAddr
);
   logic [10:0] maskReg, maskPrevReg, maskAny;
   function automatic int rank(input logic [15:0] a);
      if (a == 16'h0000) return 0;
      if (a == 16'h002C) return 1;
      return int'(a[5:2]) + 1;
   endfunction
   // mask copy seen on the bus, old value kept one cycle for latency
   assign maskAny = maskReg | maskPrevReg;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         maskReg <= 11'h000;
         maskPrevReg <= 11'h000;
      end else begin
         maskPrevReg <= maskReg;
         if (avs_write && !avs_waitrequest && avs_address == 8'h00) begin
            maskReg <= avs_writedata[10:0];
         end
      end
   end
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   property p_reset_vec;
      $past(reset_n) && !$past(reset_n, 2) |-> vectorValid && vectorAddr == 16'h0000;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("no reset vector");
   property p_reset_hold;
      vectorValid && vectorAddr == 16'h0000 && !vectorTaken |=> vectorValid && vectorAddr == 16'h0000;
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("reset vector lost");
   property p_vec_table;
      vectorValid |-> vectorAddr[1:0] == 2'h0 && vectorAddr <= 16'h002C;
   endproperty
   a_vec_table: assert property (p_vec_table) else $error("vector off table");
   property p_mask;
      vectorValid && vectorAddr != 16'h0000 && vectorAddr != 16'h002C |-> maskAny[vectorAddr[5:2]];
   endproperty
   a_mask: assert property (p_mask) else $error("masked level presented");
   property p_pwd;
      powerDownEvent |-> ##[1:4] vectorValid;
   endproperty
   a_pwd: assert property (p_pwd) else $error("power-down not presented");
   property p_take;
      vectorValid && vectorTaken |=> !vectorValid;
   endproperty
   a_take: assert property (p_take) else $error("vector kept after take");
   property p_prio;
      vectorValid && $past(vectorValid) && !$past(vectorTaken) && vectorAddr != $past(vectorAddr)
         |-> rank(vectorAddr) < rank($past(vectorAddr));
   endproperty
   a_prio: assert property (p_prio) else $error("vector replaced by lower");
   property p_flag_reset;
      $past(reset_n) && !$past(reset_n, 2) |-> flagPinOe == 4'h0 && flagPinOut == 4'h0;
   endproperty
   a_flag_reset: assert property (p_flag_reset) else $error("flag pins not inputs");
   c_pwd: cover property (vectorValid && vectorTaken && vectorAddr == 16'h002C);
   c_timer: cover property (vectorValid && vectorTaken && vectorAddr == 16'h0028);
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind piv_controller piv_checker piv_checker_i (.*);

// ===== piv_source_model.sv
// pin and event source model facing the interrupt controller
`timescale 1ns/1ps
module piv_source_model (
   input wire logic clock,
   input wire logic [3:0] flagPinOut,
   input wire logic [3:0] flagPinOe,
   input wire logic serial1FlagOutput,
   output logic [3:0] flagPinIn,
   output logic s1RecvFrameIrqPin,
   output logic s1XmitFrameIrqPin,
   output logic serial1FlagInput,
   output logic timerEvent,
   output logic bdmaDoneEvent,
   output logic sp0XmitEvent,
   output logic sp0RecvEvent,
   output logic sp1XmitEvent,
   output logic sp1RecvEvent,
   output logic powerDownEvent,
   output logic powerUpWake
);
   // released request lines rest pulled high
   logic [5:0] pinLevel = 6'h3F;
   logic [7:0] evt = 8'h00;
   // a pin driven by its own flag output reads back that level
   assign flagPinIn = (flagPinOe & flagPinOut) | (~flagPinOe & pinLevel[3:0]);
   assign s1RecvFrameIrqPin = pinLevel[4];
   assign s1XmitFrameIrqPin = pinLevel[5];
   // flag input loops back the inverted flag output
   assign serial1FlagInput = ~serial1FlagOutput;
   assign {powerUpWake, powerDownEvent, sp1RecvEvent, sp1XmitEvent} = evt[7:4];
   assign {sp0RecvEvent, sp0XmitEvent, bdmaDoneEvent, timerEvent} = evt[3:0];
   task automatic setPin(input int n, input logic v);
      pinLevel[n] <= v;
   endtask
   task automatic pulse(input int n, input int len);
      evt[n] <= 1'b1;
      repeat (len) @(posedge clock);
      evt[n] <= 1'b0;
   endtask
endmodule

// ===== testbench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic vectorTaken = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, vectorValid, serial1FlagOutput;
   logic [15:0] vectorAddr;
   logic [3:0] flagPinIn, flagPinOut, flagPinOe;
   logic s1RecvFrameIrqPin, s1XmitFrameIrqPin, serial1FlagInput, powerUpWake;
   logic timerEvent, bdmaDoneEvent, sp0XmitEvent, sp0RecvEvent;
   logic sp1XmitEvent, sp1RecvEvent, powerDownEvent;
   logic [10:0] pend;
   int errors = 0;
   int samples_checked = 0;
   logic [15:0] vecTab [11] = '{16'h002C, 16'h0004, 16'h0008, 16'h000C, 16'h0010, 16'h0014,
      16'h0018, 16'h001C, 16'h0020, 16'h0024, 16'h0028};
   int evLvl [7] = '{10, 7, 4, 5, 8, 9, 0};
   int pinIdx [9] = '{0, 1, 2, 3, 3, 4, 4, 5, 5};
   int pinLvl [9] = '{6, 3, 2, 1, 1, 9, 9, 8, 8};
   bit pinEdge [9] = '{1, 0, 0, 0, 1, 0, 1, 1, 0};
   logic [31:0] pinCtl [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h8, 32'hA, 32'hC, 32'h8};
   piv_controller piv_controller_i (.*);
   piv_source_model srcModel (.*);
   always #10 clock = ~clock;
   function automatic int lowestSet(input logic [10:0] p);
      for (int i = 0; i < 11; i++) begin
         if (p[i]) return i;
      end
      return 0;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic timedOut;
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      stop_test();
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) timedOut();
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask
   task automatic takeVec(input logic [15:0] exp, input int rel);
      int n;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (vectorValid !== 1'b1 && n < 20);
      if (n >= 20) timedOut();
      check(vectorAddr, exp);
      @(posedge clock);
      vectorTaken <= 1'b1;
      if (rel >= 0) srcModel.setPin(rel, 1'b1);
      @(posedge clock);
      vectorTaken <= 1'b0;
   endtask
   task automatic noVec;
      repeat (6) @(negedge clock);
      check(vectorValid, 1'b0);
      @(posedge clock);
   endtask
   initial begin
      void'($urandom(74));
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      takeVec(16'h0000, -1);
      bus(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0);
      check(flagPinOe, 4'h0);
      bus(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, 8'h00, 32'h7FF);
      bus(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      for (int k = 0; k < 9; k++) begin
         bus(1'b1, 8'h04, pinCtl[k]);
         srcModel.setPin(pinIdx[k], 1'b0);
         takeVec(vecTab[pinLvl[k]], -1);
         if (pinEdge[k]) begin
            noVec();
            srcModel.setPin(pinIdx[k], 1'b1);
         end else begin
            takeVec(vecTab[pinLvl[k]], pinIdx[k]);
         end
      end
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b1, 8'h08, 32'h8);
      check(flagPinOe, 4'h8);
      takeVec(16'h0004, -1);
      bus(1'b1, 8'h08, 32'h0);
      noVec();
      bus(1'b1, 8'h04, 32'h20);
      check(serial1FlagOutput, 1'b1);
      bus(1'b0, 8'h10, 32'h0);
      check(rd[20], 1'b0);
      bus(1'b1, 8'h04, 32'h0);
      for (int k = 0; k < 7; k++) begin
         srcModel.pulse(k, 1 + $urandom_range(2));
         takeVec(vecTab[evLvl[k]], -1);
      end
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h0C, 32'h20);
      noVec();
      srcModel.pulse(6, 1);
      takeVec(16'h002C, -1);
      bus(1'b1, 8'h00, 32'h7FF);
      takeVec(16'h0014, -1);
      bus(1'b1, 8'h04, 32'h10);
      srcModel.pulse(7, 1);
      takeVec(16'h0000, -1);
      bus(1'b1, 8'h04, 32'h0);
      srcModel.pulse(7, 1);
      noVec();
      for (int r = 0; r < 8; r++) begin
         pend = (r == 0) ? 11'h7FF : (11'($urandom) | 11'h400);
         bus(1'b1, 8'h0C, 32'(pend));
         while (pend != 11'h000) begin
            takeVec(vecTab[lowestSet(pend)], -1);
            pend[lowestSet(pend)] = 1'b0;
         end
      end
      bus(1'b0, 8'h10, 32'h0);
      check(rd[11:0], 12'h000);
      check(rd[20:16], 5'h1F);
      stop_test();
   end
endmodule
